// *** design/rdsbn_defs.vh ***
// constants for the rds basic data and dynamic name block
`ifndef RDSBN_DEFS_VH
`define RDSBN_DEFS_VH

// register byte offsets
`define RB_OFS_PI       8'h00
`define RB_OFS_BASIC    8'h04
`define RB_OFS_NAME_LO  8'h08
`define RB_OFS_NAME_HI  8'h0c
`define RB_OFS_CMD      8'h10
`define RB_OFS_CHA      8'h14
`define RB_OFS_CHB      8'h18
`define RB_OFS_GAP      8'h1c
`define RB_OFS_TXT_ADDR 8'h20
`define RB_OFS_TXT_DATA 8'h24
`define RB_OFS_STATUS   8'h28

// command register bit positions
`define RB_CMD_STORE    0
`define RB_CMD_RELOAD   1
`define RB_CMD_INIT     2
`define RB_CMD_START_A  3
`define RB_CMD_START_B  4
`define RB_CMD_STOP_A   5
`define RB_CMD_STOP_B   6

// basic register fields
`define RB_BASIC_PTY_LSB 0
`define RB_BASIC_TP      8
`define RB_BASIC_MS      9

// channel config fields
`define RB_CH_MODE_LSB   0
`define RB_CH_LEN_LSB    8
`define RB_CH_PER_LSB    16
`define RB_CH_CNT_LSB    24

// reset values
`define RB_PI_RST        16'hffff
`define RB_BASIC_RST     10'h000
`define RB_NAME_RST      64'h202a20534452202a
`define RB_SPACE         8'h20

// timing: clock period and label tick in nanoseconds
`define RB_CLK_NS        8
`define RB_TICK_NS       100000000

`endif

// *** design/rdsbn_tick.v ***
// label time base: one pulse per tick period
`include "rdsbn_defs.vh"

module rdsbn_tick #(
	parameter [31:0] TICK_CYC = `RB_TICK_NS / `RB_CLK_NS
) (
	input  wire mclk,
	input  wire reset_n,
	output reg  tick_ff
);
	reg [31:0] cnt_ff;

	// free running divider
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff  <= 32'h0000_0000;
			tick_ff <= 1'b0;
		end else if (cnt_ff >= TICK_CYC - 32'h0000_0001) begin
			cnt_ff  <= 32'h0000_0000;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= cnt_ff + 32'h0000_0001;
			tick_ff <= 1'b0;
		end
	end
endmodule

// *** design/rdsbn_seq.v ***
// one dynamic name channel: label position, hold timer and loop count
module rdsbn_seq (
	input  wire       mclk,
	input  wire       reset_n,
	input  wire       tick,
	input  wire       start,
	input  wire       stop,
	input  wire [7:0] period,
	input  wire [7:0] count,
	input  wire [7:0] gap,
	input  wire [9:0] step,
	input  wire       last,
	output reg  [9:0] pos_ff,
	output wire       active,
	output wire       in_gap
);
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_SHOW = 2'b01;
	localparam [1:0] ST_GAP  = 2'b10;

	reg  [1:0] state_ff;
	reg  [7:0] hold_ff;
	reg  [7:0] loop_ff;
	wire [7:0] per_m = (period == 8'h00) ? 8'h01 : period;
	wire [7:0] cnt_m = (count == 8'h00) ? 8'h01 : count;

	assign active = (state_ff != ST_IDLE);
	assign in_gap = (state_ff == ST_GAP);

	// label stepping and loop sequencing
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			pos_ff   <= 10'h000;
			hold_ff  <= 8'h00;
			loop_ff  <= 8'h00;
		end else if (stop) begin
			state_ff <= ST_IDLE;
		end else if (start) begin
			state_ff <= ST_SHOW;
			pos_ff   <= 10'h000;
			hold_ff  <= 8'h00;
			loop_ff  <= 8'h00;
		end else begin
			case (state_ff)
			ST_SHOW: begin
				if (tick) begin
					if (hold_ff + 8'h01 >= per_m) begin
						hold_ff <= 8'h00;
						if (last) begin
							pos_ff <= 10'h000;
							if (loop_ff + 8'h01 >= cnt_m) begin
								state_ff <= ST_IDLE;
							end else begin
								loop_ff  <= loop_ff + 8'h01;
								state_ff <= ST_GAP;
							end
						end else begin
							pos_ff <= pos_ff + step;
						end
					end else begin
						hold_ff <= hold_ff + 8'h01;
					end
				end
			end
			ST_GAP: begin
				if (gap == 8'h00) begin
					state_ff <= ST_SHOW;
				end else if (tick) begin
					if (hold_ff + 8'h01 >= gap) begin
						hold_ff  <= 8'h00;
						state_ff <= ST_SHOW;
					end else begin
						hold_ff <= hold_ff + 8'h01;
					end
				end
			end
			default: begin
				state_ff <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// *** design/rdsbn_core.v ***
// rds basic data registers with two dynamic service name channels
//
// Contract
// - hold a four hex digit program identifier that distinguishes the program.
// - after factory initialization the identifier reads ffff.
// - static service name is eight characters for display.
// - carry a five bit program type code selecting a category.
// - carry one traffic program flag.
// - carry a two state music or speech flag.
// - send updates working copy only; store also updates nonvolatile copy.
// - at power up transmit from nonvolatile copy; working copy is lost; reset also sets the nonvolatile copy to factory values.
// - accept dynamic texts up to 255 characters in every mode.
// - two independent dynamic channels with own text, mode, period, count.
// - repeat text loop count times, default name during static gap.
// - modes: step eight, step one, word aligned, step one space framed.
// - mode may change while running without rewriting the text.
`include "rdsbn_defs.vh"

module rdsbn_core #(
	parameter [31:0] TICK_CYC = `RB_TICK_NS / `RB_CLK_NS
) (
	input  wire        mclk,
	input  wire        reset_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [15:0] pi_code,
	output reg  [4:0]  pty_code,
	output reg         tp_flag,
	output reg         ms_flag,
	output reg  [63:0] label,
	output reg         label_new,
	output reg         dyn_active
);
	// working copy, transmitted
	reg [15:0] pi_ff;
	reg [9:0]  basic_ff;
	reg [63:0] name_ff;
	// nonvolatile copy
	reg [15:0] nv_pi_ff;
	reg [9:0]  nv_basic_ff;
	reg [63:0] nv_name_ff;
	// dynamic channel settings, channel a low word
	reg [63:0] cfg_ff;
	reg [7:0]  gap_ff;
	reg [8:0]  txt_ptr_ff;
	reg        boot_ff;
	reg [7:0]  txt_mem [0:511];

	wire        acc  = psel & penable;
	wire        done = acc & pready;
	wire        wr   = done & pwrite;
	wire        tick;
	wire [19:0] pos_w;
	wire [1:0]  act_w;
	wire [1:0]  gap_w;
	wire [1:0]  last_w;
	wire [1:0]  start_w;
	wire [1:0]  stop_w;
	wire [127:0] lab_w;
	reg  [19:0] step_r;
	reg  [31:0] rd_data;
	reg  [63:0] nxt_label;
	integer     c;
	integer     i;

	// decode of a mapped, word aligned offset
	function mapped;
		input [7:0] a;
		begin
			mapped = (a[1:0] == 2'b00) && (a <= `RB_OFS_STATUS);
		end
	endfunction

	// one label character: framing, padding and text lookup
	function [7:0] char_at;
		input       ch;
		input [9:0] pos;
		input [2:0] k;
		input [1:0] mode;
		input [7:0] len;
		reg   [10:0] t;
		begin
			t = {1'b0, pos} + {8'h00, k};
			if (mode == 2'd3) begin
				if (t < 11'd8) begin
					t = 11'h7ff; // leading frame space
				end else begin
					t = t - 11'd8;
				end
			end
			if (t >= {3'b000, len}) begin
				char_at = `RB_SPACE;
			end else begin
				char_at = txt_mem[{ch, t[7:0]}];
			end
		end
	endfunction

	// label period time base
	rdsbn_tick #(
		.TICK_CYC (TICK_CYC)
	) u_tick (
		.mclk    (mclk),
		.reset_n (reset_n),
		.tick_ff (tick)
	);

	// the two dynamic channels and their label builders
	genvar g;
	genvar k;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_ch
			wire [1:0] mode = cfg_ff[32*g + `RB_CH_MODE_LSB +: 2];
			wire [7:0] len  = cfg_ff[32*g + `RB_CH_LEN_LSB +: 8];
			wire [9:0] vlen = {2'b00, len} + ((mode == 2'd3) ? 10'd16 : 10'd0);

			assign start_w[g] = wr && (paddr == `RB_OFS_CMD)
				&& pwdata[`RB_CMD_START_A + g] && (len != 8'h00);
			assign stop_w[g]  = wr && (paddr == `RB_OFS_CMD)
				&& pwdata[`RB_CMD_STOP_A + g];
			assign last_w[g]  = (pos_w[10*g +: 10] + 10'd8 >= vlen);

			for (k = 0; k < 8; k = k + 1) begin : g_slot
				localparam [2:0] SLOT = k;
				localparam       CHSEL = (g == 1) ? 1'b1 : 1'b0;
				assign lab_w[64*g + 8*k +: 8] = char_at(CHSEL, pos_w[10*g +: 10],
					SLOT, mode, len);
			end

			rdsbn_seq u_seq (
				.mclk    (mclk),
				.reset_n (reset_n),
				.tick    (tick),
				.start   (start_w[g]),
				.stop    (stop_w[g]),
				.period  (cfg_ff[32*g + `RB_CH_PER_LSB +: 8]),
				.count   (cfg_ff[32*g + `RB_CH_CNT_LSB +: 8]),
				.gap     (gap_ff),
				.step    (step_r[10*g +: 10]),
				.last    (last_w[g]),
				.pos_ff  (pos_w[10*g +: 10]),
				.active  (act_w[g]),
				.in_gap  (gap_w[g])
			);
		end
	endgenerate

	// step size per mode; word mode jumps past the last space in the first seven characters
	always @* begin
		step_r = 20'h00000;
		for (c = 0; c < 2; c = c + 1) begin
			case (cfg_ff[32*c + `RB_CH_MODE_LSB +: 2])
			2'd0: begin
				step_r[10*c +: 10] = 10'd8;
			end
			2'd2: begin
				step_r[10*c +: 10] = 10'd8;
				for (i = 1; i < 8; i = i + 1) begin
					if (lab_w[64*c + 8*(i-1) +: 8] == `RB_SPACE) begin
						step_r[10*c +: 10] = i[9:0];
					end
				end
			end
			default: begin
				step_r[10*c +: 10] = 10'd1;
			end
			endcase
		end
	end

	// register read mux
	always @* begin
		rd_data = 32'h0000_0000;
		case (paddr)
		`RB_OFS_PI:       rd_data = {16'h0000, pi_ff};
		`RB_OFS_BASIC:    rd_data = {22'h000000, basic_ff};
		`RB_OFS_NAME_LO:  rd_data = name_ff[31:0];
		`RB_OFS_NAME_HI:  rd_data = name_ff[63:32];
		`RB_OFS_CHA:      rd_data = cfg_ff[31:0];
		`RB_OFS_CHB:      rd_data = cfg_ff[63:32];
		`RB_OFS_GAP:      rd_data = {24'h000000, gap_ff};
		`RB_OFS_TXT_ADDR: rd_data = {23'h000000, txt_ptr_ff};
		`RB_OFS_TXT_DATA: rd_data = {24'h000000, txt_mem[txt_ptr_ff]};
		`RB_OFS_STATUS: begin
			rd_data = {gap_w[1], act_w[1], gap_w[0], act_w[0], 2'b00,
				pos_w[19:10], 6'h00, pos_w[9:0]};
		end
		default:          rd_data = 32'h0000_0000;
		endcase
	end

	// apb slave: one wait state, error on unmapped offsets
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc & ~pready;
			pslverr <= acc & ~pready & ~mapped(paddr);
			if (acc && !pready) begin
				prdata <= mapped(paddr) ? rd_data : 32'h0000_0000;
			end
		end
	end

	// working copy: writes, factory init, power up and reload from nonvolatile
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pi_ff    <= `RB_PI_RST;
			basic_ff <= `RB_BASIC_RST;
			name_ff  <= `RB_NAME_RST;
			boot_ff  <= 1'b1;
		end else begin
			boot_ff <= 1'b0;
			if (wr && paddr == `RB_OFS_CMD && pwdata[`RB_CMD_INIT]) begin
				pi_ff    <= `RB_PI_RST;
				basic_ff <= `RB_BASIC_RST;
				name_ff  <= `RB_NAME_RST;
			end else if (boot_ff ||
				(wr && paddr == `RB_OFS_CMD && pwdata[`RB_CMD_RELOAD])) begin
				pi_ff    <= nv_pi_ff;
				basic_ff <= nv_basic_ff;
				name_ff  <= nv_name_ff;
			end else if (wr) begin
				case (paddr)
				`RB_OFS_PI:      pi_ff <= pwdata[15:0];
				`RB_OFS_BASIC:   basic_ff <= pwdata[9:0];
				`RB_OFS_NAME_LO: name_ff[31:0] <= pwdata;
				`RB_OFS_NAME_HI: name_ff[63:32] <= pwdata;
				default:         pi_ff <= pi_ff;
				endcase
			end
		end
	end

	// nonvolatile copy: only reset, the store command or factory init changes it
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			nv_pi_ff    <= `RB_PI_RST;
			nv_basic_ff <= `RB_BASIC_RST;
			nv_name_ff  <= `RB_NAME_RST;
		end else if (wr && paddr == `RB_OFS_CMD && pwdata[`RB_CMD_INIT]) begin
			nv_pi_ff    <= `RB_PI_RST;
			nv_basic_ff <= `RB_BASIC_RST;
			nv_name_ff  <= `RB_NAME_RST;
		end else if (wr && paddr == `RB_OFS_CMD && pwdata[`RB_CMD_STORE]) begin
			nv_pi_ff    <= pi_ff;
			nv_basic_ff <= basic_ff;
			nv_name_ff  <= name_ff;
		end
	end

	// channel settings and text pointer
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_ff     <= 64'h0000_0000_0000_0000;
			gap_ff     <= 8'h00;
			txt_ptr_ff <= 9'h000;
		end else if (wr) begin
			case (paddr)
			`RB_OFS_CHA:      cfg_ff[31:0] <= pwdata;
			`RB_OFS_CHB:      cfg_ff[63:32] <= pwdata;
			`RB_OFS_GAP:      gap_ff <= pwdata[7:0];
			`RB_OFS_TXT_ADDR: txt_ptr_ff <= pwdata[8:0];
			`RB_OFS_TXT_DATA: txt_ptr_ff <= {txt_ptr_ff[8], txt_ptr_ff[7:0] + 8'h01};
			default:          gap_ff <= gap_ff;
			endcase
		end
	end

	// text storage, two pages of 256 characters
	always @(posedge mclk) begin
		if (wr && paddr == `RB_OFS_TXT_DATA) begin
			txt_mem[txt_ptr_ff] <= pwdata[7:0];
		end
	end

	// label choice: channel a first, then b, else the static name
	always @* begin
		if (act_w[0] && !gap_w[0]) begin
			nxt_label = lab_w[63:0];
		end else if (act_w[1] && !gap_w[1]) begin
			nxt_label = lab_w[127:64];
		end else begin
			nxt_label = name_ff;
		end
	end

	// transmitted outputs
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pi_code    <= `RB_PI_RST;
			pty_code   <= 5'h00;
			tp_flag    <= 1'b0;
			ms_flag    <= 1'b0;
			label      <= `RB_NAME_RST;
			label_new  <= 1'b0;
			dyn_active <= 1'b0;
		end else begin
			pi_code    <= pi_ff;
			pty_code   <= basic_ff[`RB_BASIC_PTY_LSB +: 5];
			tp_flag    <= basic_ff[`RB_BASIC_TP];
			ms_flag    <= basic_ff[`RB_BASIC_MS];
			label      <= nxt_label;
			label_new  <= (nxt_label != label);
			dyn_active <= act_w[0] | act_w[1];
		end
	end
endmodule

// *** sim/rdsbn_chk.sv ***
// concurrent checks on the ports of the rds basic data block
`include "rdsbn_defs.vh"
module rdsbn_chk #(
	parameter [31:0] TICK_CYC = 32'd8
) (
	input wire        mclk,
	input wire        reset_n,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire [15:0] pi_code,
	input wire [4:0]  pty_code,
	input wire        tp_flag,
	input wire        ms_flag,
	input wire [63:0] label,
	input wire        label_new,
	input wire        dyn_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// accepted write and address decode
	wire wr_ok    = pready && pwrite && !pslverr;
	wire bad_addr = (paddr[1:0] != 2'b00) || (paddr > `RB_OFS_STATUS);

	// first access cycle, then the one-cycle answer
	sequence s_access_start;
		psel && penable && !pready && !$past(penable);
	endsequence
	sequence s_answer;
		!pready ##1 (pready && psel && penable);
	endsequence

	AST_PREADY_LATENCY: assert property (s_access_start |-> s_answer)
		else $error("pready not one cycle after first access cycle");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	AST_PREADY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	AST_SLVERR_DECODE: assert property (pready |-> (pslverr == bad_addr))
		else $error("pslverr does not match address decode");
	AST_ERR_RDATA_ZERO: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused transfer returned nonzero data");
	AST_PI_WRITE: assert property (
		wr_ok && paddr == `RB_OFS_PI |-> ##2 pi_code == $past(pwdata[15:0], 2))
		else $error("identifier not taken from write");
	AST_BASIC_WRITE: assert property (
		wr_ok && paddr == `RB_OFS_BASIC |-> ##2 {ms_flag, tp_flag, pty_code} ==
		{$past(pwdata[9], 2), $past(pwdata[8], 2), $past(pwdata[4:0], 2)})
		else $error("type or flags not taken from write");
	AST_LABEL_NEW: assert property (label_new == !$stable(label))
		else $error("label change pulse does not match label change");
	AST_PI_READBACK: assert property (
		pready && !pwrite && !pslverr && paddr == `RB_OFS_PI |-> prdata[15:0] == pi_code)
		else $error("identifier read differs from output");
	AST_PI_HELD: assert property (
		!$stable(pi_code) |-> $past(wr_ok) || $past(wr_ok, 2))
		else $error("identifier changed without a write");
	AST_LABEL_IDLE: assert property (
		(!dyn_active && !wr_ok)[*4] |=> $stable(label))
		else $error("idle label changed without a write");
endmodule

bind rdsbn_core rdsbn_chk #(.TICK_CYC(TICK_CYC)) i_rdsbn_chk (
	.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pi_code(pi_code), .pty_code(pty_code),
	.tp_flag(tp_flag), .ms_flag(ms_flag), .label(label), .label_new(label_new),
	.dyn_active(dyn_active)
);

// *** sim/rdsbn_host.sv ***
// apb host model standing in for the control computer
module rdsbn_host (
	input  wire         mclk,
	output logic        psel,
	output logic        penable,
	output logic        pwrite,
	output logic [7:0]  paddr,
	output logic [31:0] pwdata,
	input  wire  [31:0] prdata,
	input  wire         pready,
	input  wire         pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// one transfer; request held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the rds basic data block
`include "rdsbn_defs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [31:0] TICK = 32'd8;
	logic        mclk;
	logic        reset_n;
	wire         psel, penable, pwrite, pready, pslverr;
	wire  [7:0]  paddr;
	wire  [31:0] pwdata, prdata;
	wire  [15:0] pi_code;
	wire  [4:0]  pty_code;
	wire         tp_flag, ms_flag, label_new, dyn_active;
	wire  [63:0] label;
	logic [31:0] rd_data;
	logic        rd_err;
	int          err_count;
	int          tests_run;

	rdsbn_core #(.TICK_CYC(TICK)) i_rdsbn_core (
		.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pi_code(pi_code), .pty_code(pty_code),
		.tp_flag(tp_flag), .ms_flag(ms_flag), .label(label), .label_new(label_new),
		.dyn_active(dyn_active));
	rdsbn_host i_host (
		.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// 125 mhz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input [63:0] got, input [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one register access; refusal expected for unaligned or unmapped offsets
	task automatic acc(input w, input [7:0] a, input [31:0] d, input [31:0] x);
		logic bad;
		bad = (a > `RB_OFS_STATUS) || (a[1:0] != 2'b00);
		i_host.xfer(w, a, d, rd_data, rd_err);
		chk({63'h0, rd_err}, {63'h0, bad});
		if (!w) chk({32'h0, rd_data}, {32'h0, x});
	endtask

	// eight-character label, short text padded with spaces
	function automatic [63:0] lab(input string s);
		for (int k = 0; k < 8; k++) lab[8*k +: 8] = (k < s.len()) ? s[k] : 8'h20;
	endfunction

	function automatic [31:0] cfg(input [1:0] m, input [7:0] len, per, cnt);
		cfg = {cnt, per, len, 6'h00, m};
	endfunction

	task automatic txt(input ch, input string s);
		acc(1, `RB_OFS_TXT_ADDR, {23'h0, ch, 8'h00}, 0);
		for (int i = 0; i < s.len(); i++) acc(1, `RB_OFS_TXT_DATA, {24'h0, s[i]}, 0);
	endtask

	// bounded wait for a label to appear
	task automatic wait_lab(input string s);
		int n;
		n = 0;
		while (label !== lab(s) && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk(label, lab(s));
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (dyn_active !== 1'b0 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk({63'h0, dyn_active}, 64'h0);
	endtask

	// watchdog
	initial begin
		repeat (40000) @(posedge mclk);
		err_count++;
		close_out;
	end

	initial begin
		reset_n = 1'b0;
		err_count = 0;
		tests_run = 0;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		chk({48'h0, pi_code}, 64'hffff);
		chk(label, lab("* RDS * "));
		chk({57'h0, pty_code, tp_flag, ms_flag, dyn_active}, 64'h0);
		acc(0, `RB_OFS_PI, 0, 32'h0000ffff);
		acc(1, `RB_OFS_PI, 32'h0000c0a5, 0);
		acc(0, `RB_OFS_PI, 0, 32'h0000c0a5);
		acc(1, `RB_OFS_BASIC, 32'h00000303, 0);
		repeat (2) @(posedge mclk);
		chk({59'h0, ms_flag, tp_flag, pty_code[2:0]}, 64'h1b);
		acc(1, `RB_OFS_BASIC, 32'h0000001f, 0);
		repeat (2) @(posedge mclk);
		chk({57'h0, ms_flag, tp_flag, pty_code}, 64'h1f);
		acc(0, 8'h2c, 0, 0);
		acc(1, 8'h02, 32'h00001234, 0);
		chk({48'h0, pi_code}, 64'hc0a5);
		acc(1, `RB_OFS_NAME_LO, 32'h49444152, 0);
		acc(1, `RB_OFS_NAME_HI, 32'h2031204f, 0);
		wait_lab("RADIO 1 ");
		// store, send only, reload from nonvolatile, then factory init
		acc(1, `RB_OFS_CMD, 32'h1, 0);
		acc(1, `RB_OFS_PI, 32'h0000c111, 0);
		repeat (2) @(posedge mclk);
		chk({48'h0, pi_code}, 64'hc111);
		acc(1, `RB_OFS_CMD, 32'h2, 0);
		repeat (3) @(posedge mclk);
		chk({48'h0, pi_code}, 64'hc0a5);
		acc(1, `RB_OFS_CMD, 32'h4, 0);
		repeat (3) @(posedge mclk);
		chk({48'h0, pi_code}, 64'hffff);
		wait_lab("* RDS * ");
		// channel a, step by eight, two loops with a static gap
		acc(1, `RB_OFS_GAP, 32'h2, 0);
		txt(0, "ABCDEFGHIJ");
		acc(1, `RB_OFS_CHA, cfg(2'd0, 8'd10, 8'd1, 8'd2), 0);
		acc(1, `RB_OFS_CMD, 32'h8, 0);
		wait_lab("ABCDEFGH");
		wait_lab("IJ");
		wait_lab("* RDS * ");
		wait_lab("ABCDEFGH");
		wait_lab("IJ");
		wait_idle;
		// channel b, mode switched while running
		txt(1, "ABCDEFGHIJKLMNOP");
		acc(1, `RB_OFS_CHB, cfg(2'd0, 8'd16, 8'd3, 8'd1), 0);
		acc(1, `RB_OFS_CMD, 32'h10, 0);
		wait_lab("ABCDEFGH");
		acc(1, `RB_OFS_CHB, cfg(2'd1, 8'd16, 8'd3, 8'd1), 0);
		wait_lab("BCDEFGHI");
		wait_lab("CDEFGHIJ");
		acc(1, `RB_OFS_CMD, 32'h40, 0);
		wait_idle;
		// channel a text kept, space framed mode
		acc(1, `RB_OFS_CHA, cfg(2'd3, 8'd10, 8'd1, 8'd1), 0);
		acc(1, `RB_OFS_CMD, 32'h8, 0);
		wait_lab("        ");
		wait_lab("       A");
		wait_lab("J");
		wait_idle;
		// word aligned mode
		txt(0, "AB CD EFGHIJK");
		acc(1, `RB_OFS_CHA, cfg(2'd2, 8'd13, 8'd1, 8'd1), 0);
		acc(1, `RB_OFS_CMD, 32'h8, 0);
		wait_lab("AB CD EF");
		wait_lab("EFGHIJK");
		wait_idle;
		// longest text, last label padded
		acc(1, `RB_OFS_TXT_ADDR, 32'h0, 0);
		for (int i = 0; i < 255; i++) acc(1, `RB_OFS_TXT_DATA, 32'h41 + i % 26, 0);
		acc(1, `RB_OFS_CHA, cfg(2'd0, 8'd255, 8'd1, 8'd1), 0);
		acc(1, `RB_OFS_CMD, 32'h8, 0);
		wait_lab("OPQRSTU");
		wait_idle;
		close_out;
	end
endmodule
